// [rtl/erxw_divider.sv]
// divider: one-cycle enable pulse every period cycles
`timescale 1ns/1ps
module erxw_divider #(
   parameter int PERIOD = 20
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control and output pulse
   input wire logic run,
   output logic tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } erxw_div_t;
   erxw_div_t st, next_st;
   // count down and pulse at zero
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!run) begin
         // one short on restart: the pulse is registered, so its user sees it a cycle later
         next_st.cnt = 16'(PERIOD - 2);
      end else if (st.cnt == 16'h0000) begin
         next_st.cnt = 16'(PERIOD - 1);
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt - 16'h0001;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign tick = st.tick;
endmodule

// [rtl/erxw_gap_timer.sv]
// gap timer: counts a back-to-back gap in nibble times
`timescale 1ns/1ps
module erxw_gap_timer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // nibble pulse, start and length
   input wire logic nib_tick,
   input wire logic start,
   input wire logic [7:0] len,
   // status
   output logic busy
);
   typedef struct packed {
      logic [7:0] left;
      logic busy;
   } erxw_gap_t;
   erxw_gap_t st, next_st;
   // load on start, count down one per nibble time
   always_comb begin
      next_st = st;
      if (start) begin
         next_st.left = len;
         next_st.busy = 1'b1;
      end else if (st.busy && nib_tick) begin
         if (st.left <= 8'h01) begin
            next_st.busy = 1'b0;
            next_st.left = 8'h00;
         end else begin
            next_st.left = st.left - 8'h01;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign busy = st.busy;
endmodule

// [rtl/erxw_pkg.sv]
// package: register map, field positions, reset values and timing for the ethernet init block
package erxw_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_FILTER = 8'h08;
   localparam logic [7:0] OFF_PKTCNT = 8'h0C;
   localparam logic [7:0] OFF_RXST = 8'h10;
   localparam logic [7:0] OFF_RXND = 8'h14;
   localparam logic [7:0] OFF_RXWR = 8'h18;
   localparam logic [7:0] OFF_RXRDL = 8'h1C;
   localparam logic [7:0] OFF_RXRDH = 8'h20;
   localparam logic [7:0] OFF_MACCTL = 8'h24;
   localparam logic [7:0] OFF_B2B = 8'h28;
   localparam logic [7:0] OFF_NB2B = 8'h2C;
   localparam logic [7:0] OFF_MAXFL = 8'h30;
   localparam logic [7:0] OFF_PHYCTL = 8'h34;
   localparam logic [7:0] OFF_INTEN = 8'h38;
   // field positions
   localparam int CTRL_ENABLE_BIT = 5;
   localparam int CTRL_PKTDEC_BIT = 6;
   localparam int STAT_PHY_READY_FLAG_BIT = 0;
   localparam int STAT_PENDING_BIT = 1;
   localparam int STAT_WAKE_BIT = 2;
   localparam int FILT_CRC_BIT = 5;
   localparam int FILT_WAKE_BIT = 3;
   localparam int MAC1_RXEN_BIT = 0;
   localparam int MAC3_FDX_BIT = 0;
   localparam int INT_PKT_BIT = 6;
   localparam int INT_GLOBAL_BIT = 7;
   localparam int B2B_WIDTH = 7;
   localparam int FDX_GAP_OFFSET = 3;
   localparam int HDX_GAP_OFFSET = 6;
   // reset values
   localparam logic [7:0] B2B_RESET = 8'h00;
   localparam logic [12:0] PTR_RESET = 13'h0000;
   localparam logic [7:0] PKTCNT_MAX = 8'hFF;
   // timing: 50 mhz clock, 10 mbit/s line, nibble time is four bit times
   localparam int CLK_HZ = 50_000_000;
   localparam int BIT_NS = 100;
   localparam int NIBBLE_BITS = 4;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int NIBBLE_CYCLES = (NIBBLE_BITS * BIT_NS) / CLK_NS;
   localparam int PHY_START_US = 1000;
   localparam int PHY_START_CYCLES = (PHY_START_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // receive event from the line side
   typedef struct packed {
      logic done;
      logic good;
      logic wake;
   } erxw_rx_ev_t;
endpackage

// [rtl/erxw_top.sv]
// top: receive pending flag, wake, buffer pointers, phy ready wait, mac gap config
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module erxw_top import erxw_pkg::*; #(
   parameter int PHY_CYCLES = PHY_START_CYCLES,
   parameter int PTR_W = 13
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // receive events from the line side (same clock)
   input wire erxw_rx_ev_t rx_ev,
   // line side status and control
   output logic rx_accept,
   output logic rx_error,
   output logic eth_irq,
   output logic wake,
   output logic [PTR_W-1:0] rx_wr_ptr,
   // transmit gap request
   input wire logic tx_end,
   output logic tx_gap_busy
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ctrl;
      logic [7:0] filter;
      logic [7:0] pktcnt;
      logic [PTR_W-1:0] rxst;
      logic [PTR_W-1:0] rxnd;
      logic [PTR_W-1:0] rxwr;
      logic [PTR_W-1:0] rxrd;
      logic [7:0] rxrd_low_hold;
      logic [7:0] mac1;
      logic [7:0] mac3;
      logic [7:0] mac4;
      logic [6:0] b2b;
      logic [15:0] nb2b;
      logic [15:0] maxfl;
      logic [31:0] phyctl;
      logic [7:0] inten;
      logic [23:0] phy_cnt;
      logic phy_ready;
      logic wake;
      logic irq;
      logic rx_error;
      logic rx_open;
   } erxw_state_t;
   erxw_state_t st, next_st;
   logic nib_tick;
   logic gap_busy;
   logic [7:0] gap_len;
   logic [31:0] rd_val;
   logic [31:0] wmask;
   logic enabled;
   assign enabled = st.ctrl[CTRL_ENABLE_BIT];
   // nibble time = four bit times of the 10 mbit/s line
   // restarted at each transmit end so a gap spans whole nibble times, not a random phase
   erxw_divider #(.PERIOD(NIBBLE_CYCLES)) u_nib (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(enabled & ~tx_end),
      .tick(nib_tick)
   );
   // back-to-back gap: field plus duplex-dependent offset
   always_comb begin
      if (st.mac3[MAC3_FDX_BIT]) begin
         gap_len = {1'b0, st.b2b} + 8'(FDX_GAP_OFFSET);
      end else begin
         gap_len = {1'b0, st.b2b} + 8'(HDX_GAP_OFFSET);
      end
   end
   erxw_gap_timer u_gap (
      .aclk(aclk),
      .aresetn(aresetn),
      .nib_tick(nib_tick),
      .start(tx_end & enabled),
      .len(gap_len),
      .busy(gap_busy)
   );
   // strobe mask for the held write data
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{st.w_strb[i]}};
      end
   end
   // read mux; unused bits read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      if (araddr == OFF_CTRL) begin
         rd_val[7:0] = st.ctrl;
      end else if (araddr == OFF_STATUS) begin
         rd_val[STAT_PHY_READY_FLAG_BIT] = st.phy_ready;
         rd_val[STAT_PENDING_BIT] = (st.pktcnt != 8'h00);
         rd_val[STAT_WAKE_BIT] = st.wake;
      end else if (araddr == OFF_FILTER) begin
         rd_val[7:0] = st.filter;
      end else if (araddr == OFF_PKTCNT) begin
         rd_val[7:0] = st.pktcnt;
      end else if (araddr == OFF_RXST) begin
         rd_val[PTR_W-1:0] = st.rxst;
      end else if (araddr == OFF_RXND) begin
         rd_val[PTR_W-1:0] = st.rxnd;
      end else if (araddr == OFF_RXWR) begin
         rd_val[PTR_W-1:0] = st.rxwr;
      end else if (araddr == OFF_RXRDL) begin
         rd_val[7:0] = st.rxrd[7:0];
      end else if (araddr == OFF_RXRDH) begin
         rd_val[PTR_W-9:0] = st.rxrd[PTR_W-1:8];
      end else if (araddr == OFF_MACCTL) begin
         rd_val[23:0] = {st.mac4, st.mac3, st.mac1};
      end else if (araddr == OFF_B2B) begin
         rd_val[7:0] = {1'b0, st.b2b};
      end else if (araddr == OFF_NB2B) begin
         rd_val[15:0] = st.nb2b;
      end else if (araddr == OFF_MAXFL) begin
         rd_val[15:0] = st.maxfl;
      end else if (araddr == OFF_PHYCTL) begin
         rd_val = st.phyctl;
      end else if (araddr == OFF_INTEN) begin
         rd_val[7:0] = st.inten;
      end
   end
   // main next-state logic
   always_comb begin
      logic [31:0] wv;
      logic do_write;
      logic hit;
      logic dec;
      logic take_pkt;
      logic full;
      wv = 32'h0000_0000;
      do_write = 1'b0;
      hit = 1'b0;
      dec = 1'b0;
      take_pkt = 1'b0;
      full = 1'b0;
      next_st = st;
      next_st.irq = 1'b0;
      next_st.rx_error = 1'b0;
      // write channel capture, either order
      if (st.awready && awvalid) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = awaddr;
         next_st.awready = 1'b0;
      end
      if (st.wready && wvalid) begin
         next_st.w_held = 1'b1;
         next_st.w_data = wdata;
         next_st.w_strb = wstrb;
         next_st.wready = 1'b0;
      end
      if (st.aw_held && st.w_held && !st.bvalid) begin
         do_write = 1'b1;
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
      end
      wv = (st.w_data & wmask);
      if (do_write) begin
         hit = 1'b1;
         if (st.aw_addr == OFF_CTRL) begin
            next_st.ctrl = wv[7:0] & ~(8'h01 << CTRL_PKTDEC_BIT);
            dec = wv[CTRL_PKTDEC_BIT];
         end else if (st.aw_addr == OFF_FILTER) begin
            next_st.filter = wv[7:0];
         end else if (st.aw_addr == OFF_RXST) begin
            next_st.rxst = wv[PTR_W-1:0];
            next_st.rxwr = wv[PTR_W-1:0];
         end else if (st.aw_addr == OFF_RXND) begin
            next_st.rxnd = wv[PTR_W-1:0];
            next_st.rxwr = st.rxst;
         end else if (st.aw_addr == OFF_RXRDL) begin
            next_st.rxrd_low_hold = wv[7:0];
         end else if (st.aw_addr == OFF_RXRDH) begin
            // low byte is held until the high byte lands, so the pair moves at once
            next_st.rxrd = {wv[PTR_W-9:0], st.rxrd_low_hold};
         end else if (st.aw_addr == OFF_MACCTL) begin
            {next_st.mac4, next_st.mac3, next_st.mac1} = wv[23:0];
         end else if (st.aw_addr == OFF_B2B) begin
            next_st.b2b = wv[B2B_WIDTH-1:0];
         end else if (st.aw_addr == OFF_NB2B) begin
            next_st.nb2b = wv[15:0];
         end else if (st.aw_addr == OFF_MAXFL) begin
            next_st.maxfl = wv[15:0];
         end else if (st.aw_addr == OFF_PHYCTL) begin
            next_st.phyctl = wv;
         end else if (st.aw_addr == OFF_INTEN) begin
            next_st.inten = wv[7:0];
         end else if (st.aw_addr == OFF_STATUS) begin
            // wake flag clears on write-one; pending flag ignores writes
            if (wv[STAT_WAKE_BIT]) begin
               next_st.wake = 1'b0;
            end
         end else begin
            hit = 1'b0;
         end
         next_st.bresp = hit ? RESP_OKAY : RESP_SLVERR;
      end
      // read channel: answer one cycle after the address is taken
      if (st.arready && arvalid) begin
         next_st.arready = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_val;
         next_st.rresp = RESP_OKAY;
         if (araddr > OFF_INTEN || araddr[1:0] != 2'b00) begin
            next_st.rresp = RESP_SLVERR;
         end
      end
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end
      // phy start-up timer; cleared when the module is disabled
      if (!enabled) begin
         next_st.phy_cnt = 24'h00_0000;
         next_st.phy_ready = 1'b0;
      end else if (!st.phy_ready) begin
         if (st.phy_cnt >= 24'(PHY_CYCLES - 1)) begin
            next_st.phy_ready = 1'b1;
         end else begin
            next_st.phy_cnt = st.phy_cnt + 24'h00_0001;
         end
      end
      // packet arrival; only while receive enabled
      full = (st.pktcnt == PKTCNT_MAX);
      if (rx_ev.done && rx_ev.good && st.rx_open) begin
         if (full) begin
            next_st.rx_error = 1'b1;
         end else begin
            take_pkt = 1'b1;
         end
      end
      // counter: arrival and software decrement may coincide
      if (take_pkt && !(dec && st.pktcnt != 8'h00)) begin
         next_st.pktcnt = st.pktcnt + 8'h01;
      end else if (!take_pkt && dec && st.pktcnt != 8'h00) begin
         next_st.pktcnt = st.pktcnt - 8'h01;
      end
      // interrupt on each stored packet when both enables set
      if (take_pkt && st.inten[INT_PKT_BIT] && st.inten[INT_GLOBAL_BIT]) begin
         next_st.irq = 1'b1;
      end
      // wake packet through crc and wake filters; set beats clear
      if (take_pkt && rx_ev.wake && st.filter[FILT_CRC_BIT] && st.filter[FILT_WAKE_BIT]) begin
         next_st.wake = 1'b1;
      end
      if (!enabled) begin
         next_st.wake = 1'b0;
      end
      // receive gate kept in a flop so the port and the arrival logic agree
      next_st.rx_open = next_st.ctrl[CTRL_ENABLE_BIT] & next_st.mac1[MAC1_RXEN_BIT];
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.b2b <= B2B_RESET[6:0];
         st.rxwr <= PTR_RESET;
      end else begin
         st <= next_st;
      end
   end
   // line side outputs, all from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_gap_busy <= 1'b0;
      end else begin
         tx_gap_busy <= gap_busy;
      end
   end
   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign rx_accept = st.rx_open;
   assign rx_error = st.rx_error;
   assign eth_irq = st.irq;
   assign wake = st.wake;
   assign rx_wr_ptr = st.rxwr;
endmodule

// [tb/erxw_line_model.sv]
// line-side model: end-of-packet events and transmit-end pulses
`timescale 1ns/1ps
module erxw_line_model import erxw_pkg::*; (
   // clock
   input wire logic aclk,
   // events toward the block
   output erxw_rx_ev_t rx_ev,
   output logic tx_end
);
   initial begin
      rx_ev = '0;
      tx_end = 1'b0;
   end
   // one-cycle packet end; flags scrambled after so nothing leans on stale values
   task automatic pkt(input logic good, input logic wk, input int idle);
      rx_ev <= '{1'b1, good, wk};
      @(posedge aclk);
      rx_ev <= '{1'b0, !good, !wk};
      repeat (idle) @(posedge aclk);
   endtask
   // end of one transmitted packet
   task automatic txe();
      tx_end <= 1'b1;
      @(posedge aclk);
      tx_end <= 1'b0;
   endtask
endmodule

// [tb/erxw_top_assertions.sv]
// checker: port-level timing of the ethernet init block
`timescale 1ns/1ps
module erxw_top_assertions import erxw_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   // line side
   input wire erxw_rx_ev_t rx_ev,
   input wire logic rx_accept,
   input wire logic rx_error,
   input wire logic eth_irq,
   input wire logic wake,
   input wire logic tx_end,
   input wire logic tx_gap_busy
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a good packet taken while receive is open
   sequence s_stored;
      rx_ev.done && rx_ev.good && rx_accept;
   endsequence
   // both halves of a write taken at one edge
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   property p_irq_cause;
      eth_irq |-> $past(rx_ev.done && rx_ev.good && rx_accept);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq with no stored packet");
   property p_err_cause;
      rx_error |-> $past(rx_ev.done && rx_ev.good && rx_accept) && !eth_irq;
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("abort without a packet");
   // a packet offered while closed leaves no trace
   property p_refused;
      rx_ev.done && !rx_accept |=> !eth_irq && !rx_error && !$rose(wake);
   endproperty
   a_refused: assert property (p_refused) else $error("closed receiver took a packet");
   property p_wake_cause;
      $rose(wake) |-> $past(rx_ev.done && rx_ev.good && rx_ev.wake && rx_accept);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake without wake packet");
   property p_gap_start;
      tx_end |-> ##[1:3] tx_gap_busy;
   endproperty
   a_gap_start: assert property (p_gap_start) else $error("gap did not start");
   // the shortest gap is three nibbles, far above eight cycles
   property p_gap_min;
      $rose(tx_gap_busy) |-> tx_gap_busy[*8];
   endproperty
   a_gap_min: assert property (p_gap_min) else $error("gap far too short");
   property p_b_hold;
      bvalid && !bready |=> bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_wr_answer;
      s_wr_taken |=> !awready ##1 bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");
   property p_rd_answer;
      arvalid && arready |=> rvalid && !arready;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read data late");
   property p_r_hold;
      rvalid && !rready |=> rvalid;
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   cover property (s_stored ##1 eth_irq);
endmodule

bind erxw_top erxw_top_assertions i_erxw_top_assertions (.aclk, .aresetn, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
   .rx_ev, .rx_accept, .rx_error, .eth_irq, .wake, .tx_end, .tx_gap_busy);

// [tb/eth_rx_pending_wake_and_mac_init_tb.sv]
// testbench: register bus driver, line model and result monitor
`timescale 1ns/1ps
module eth_rx_pending_wake_and_mac_init_tb import erxw_pkg::*;;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tx_end;
   logic awready, wready, bvalid, arready, rvalid, rx_accept, rx_error, eth_irq, wake;
   logic tx_gap_busy;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [12:0] rx_wr_ptr;
   erxw_rx_ev_t rx_ev;
   int n_errors, n_tests, n_irq, n_err, cyc;
   logic [33:0] exp_q[$];

   // short phy wait keeps the run brief
   erxw_top #(.PHY_CYCLES(20), .PTR_W(13)) i_erxw_top (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rx_ev, .rx_accept, .rx_error,
      .eth_irq, .wake, .rx_wr_ptr, .tx_end, .tx_gap_busy);
   erxw_line_model i_erxw_line_model (.aclk, .rx_ev, .tx_end);

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // one write; the trailing edge keeps bready from being driven twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, 32'h0000});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   // monitor: answers against the oldest note, event counts, hang guard
   always @(posedge aclk) begin
      if (bvalid && bready) chk({bresp, 32'h0000}, exp_q.pop_front());
      if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
      if (eth_irq === 1'b1) n_irq++;
      if (rx_error === 1'b1) n_err++;
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         finish_test();
      end
   end

   initial begin
      int k;
      int c;
      logic [12:0] st;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      void'($urandom(99556));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFF_B2B, 34'h0);
      rd(OFF_STATUS, 34'h0);
      rd(8'h3C, {RESP_SLVERR, 32'h0000});
      wr(8'h3C, 32'hFFFF_FFFF, RESP_SLVERR);
      i_erxw_line_model.pkt(1'b1, 1'b1, 2);
      rd(OFF_PKTCNT, 34'h0);
      $display("test reset done");
      wr(OFF_CTRL, 32'h0000_0020, RESP_OKAY);
      repeat (25) @(posedge aclk);
      rd(OFF_STATUS, 34'h1);
      wr(OFF_MACCTL, 32'h0000_0001, RESP_OKAY);
      wr(OFF_INTEN, 32'h0000_00C0, RESP_OKAY);
      wr(OFF_FILTER, 32'h0000_0028, RESP_OKAY);
      chk(34'(rx_accept), 34'h1);
      k = $urandom_range(8, 2);
      for (int i = 0; i < k; i++) i_erxw_line_model.pkt(1'b1, 1'b0, $urandom_range(3, 1));
      i_erxw_line_model.pkt(1'b0, 1'b0, 2);
      chk(34'(n_irq), 34'(k));
      rd(OFF_PKTCNT, 34'(k));
      wr(OFF_STATUS, 32'h0000_0003, RESP_OKAY);
      rd(OFF_STATUS, 34'h3);
      for (int i = 0; i < k; i++) begin
         wr(OFF_CTRL, 32'h0000_0060, RESP_OKAY);
         rd(OFF_STATUS, (i < k - 1) ? 34'h3 : 34'h1);
      end
      $display("test pending done");
      i_erxw_line_model.pkt(1'b1, 1'b1, 1);
      chk(34'(wake), 34'h1);
      rd(OFF_STATUS, 34'h7);
      wr(OFF_STATUS, 32'h0000_0004, RESP_OKAY);
      chk(34'(wake), 34'h0);
      wr(OFF_CTRL, 32'h0000_0060, RESP_OKAY);
      rd(OFF_STATUS, 34'h1);
      $display("test wake done");
      // even start, clear of the bottom so a transmit status vector fits below it
      st = (13'($urandom) & 13'h1FFE) | 13'h0008;
      wr(OFF_RXST, 32'(st), RESP_OKAY);
      chk(34'(rx_wr_ptr), 34'(st));
      wr(OFF_RXND, 32'(st | 13'h0001), RESP_OKAY);
      rd(OFF_RXWR, 34'(st));
      wr(OFF_RXRDL, 32'(st[7:0] | 8'h01), RESP_OKAY);
      rd(OFF_RXRDL, 34'h0);
      wr(OFF_RXRDH, 32'(st[12:8]), RESP_OKAY);
      rd(OFF_RXRDL, 34'(st[7:0] | 8'h01));
      rd(OFF_RXRDH, 34'(st[12:8]));
      wr(OFF_MAXFL, 32'h0000_05EE, RESP_OKAY);
      rd(OFF_MAXFL, 34'h05EE);
      wr(OFF_NB2B, 32'h0000_0C12, RESP_OKAY);
      rd(OFF_NB2B, 34'h0C12);
      $display("test pointers done");
      wr(OFF_B2B, 32'h0000_00FF, RESP_OKAY);
      rd(OFF_B2B, 34'h7F);
      for (int j = 0; j < 2; j++) begin
         wr(OFF_MACCTL, 32'h0040_3201 + 32'(j * 256), RESP_OKAY);
         rd(OFF_MACCTL, 34'h0040_3201 + 34'(j * 256));
         wr(OFF_PHYCTL, 32'h0110_0000 + 32'(j * 256), RESP_OKAY);
         rd(OFF_PHYCTL, 34'h0110_0000 + 34'(j * 256));
         wr(OFF_B2B, j ? 32'h0000_0015 : 32'h0000_0012, RESP_OKAY);
         i_erxw_line_model.txe();
         while (tx_gap_busy !== 1'b1) @(posedge aclk);
         c = 0;
         while (tx_gap_busy === 1'b1) begin
            c++;
            @(posedge aclk);
         end
         chk(34'(c), 34'(((j ? 'h15 : 'h12) + (j ? FDX_GAP_OFFSET : HDX_GAP_OFFSET)) * NIBBLE_CYCLES));
      end
      $display("test gap done");
      wr(OFF_INTEN, 32'h0000_0040, RESP_OKAY);
      for (int i = 0; i < 256; i++) i_erxw_line_model.pkt(1'b1, 1'b0, 1);
      // let the monitor count the last pulse before the counts are compared
      repeat (2) @(posedge aclk);
      chk(34'(n_err), 34'h1);
      chk(34'(n_irq), 34'(k + 1));
      rd(OFF_PKTCNT, 34'hFF);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFF_STATUS, 34'h0);
      $display("test overflow done");
      finish_test();
   end
endmodule
